// File: hdl/otf_pkg.sv
// Constants, types and helper functions for the over-temperature fault response block.
// Function
// - Fault threshold, 16-bit Linear, at 0x4F.
// - Warning threshold, 16-bit Linear, at 0x51.
// - Response config at 0x50; code 00 ignores.
// - Code 01: run for delay, then retry.
// - Code 10: disable at once, then retry.
// - Code 11: off while fault, resume after.
// - Retry code 000: no restart, stay off.
// - Codes 1..6: that many restarts, then latch.
// - Attempts spaced start to start by delay.
// - Code 111 retries until off, bias, fault.
// - Delay code selects 1..128 units, power two.
// - Same delay for run time and spacing.
// - Delay unit length held at 0xD2.
// - Unignored fault pulls alert low, sets flag.
package otf_pkg;

  localparam int CLK_PERIOD_NS = 50;
  // One step of the delay-unit register is one millisecond.
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYC = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] CODE_FAULT_THRESH = 8'h4F;
  localparam logic [7:0] CODE_RESP_CFG = 8'h50;
  localparam logic [7:0] CODE_WARN_THRESH = 8'h51;
  localparam logic [7:0] CODE_DELAY_UNIT = 8'hD2;

  // Reset values: 125 C fault, 110 C warning, disable without retry, 10 ms unit.
  localparam logic [15:0] RST_FAULT_THRESH = 16'hEBE8;
  localparam logic [15:0] RST_WARN_THRESH = 16'hEB70;
  localparam logic [7:0] RST_RESP_CFG = 8'h80;
  localparam logic [15:0] RST_DELAY_UNIT = 16'h000A;

  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam int LIN_EXP_HI = 15;
  localparam int LIN_MAN_HI = 10;

  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam int DELAY_W = 23;

  typedef enum logic [1:0] {
    RESP_IGNORE = 2'h0,
    RESP_RETRY_RUN = 2'h1,
    RESP_DISABLE_RETRY = 2'h2,
    RESP_RESUME_OK = 2'h3
  } otf_resp_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_CONT = 3'h1,
    ST_OFF_WAIT = 3'h3,
    ST_RESTART = 3'h2,
    ST_HOLD = 3'h6,
    ST_LATCH = 3'h7
  } otf_state_t;

  // Linear value to fixed point with 16 fraction bits; exponent plus 16 is the shift.
  function automatic logic signed [42:0] otf_lin_to_fix(input logic [15:0] v);
    logic signed [42:0] m;
    logic [4:0] sh;
    m = {{32{v[LIN_MAN_HI]}}, v[LIN_MAN_HI:0]};
    sh = {~v[LIN_EXP_HI], v[LIN_EXP_HI-1:LIN_MAN_HI+1]};
    return m <<< sh;
  endfunction : otf_lin_to_fix

  function automatic logic otf_lin_ge(input logic [15:0] a, input logic [15:0] b);
    return otf_lin_to_fix(a) >= otf_lin_to_fix(b);
  endfunction : otf_lin_ge

  // Units times two to the power of the code, in one-millisecond ticks.
  function automatic logic [DELAY_W-1:0] otf_delay_ticks(input logic [15:0] unit,
                                                        input logic [2:0] code);
    return {7'h00, unit} << code;
  endfunction : otf_delay_ticks

endpackage : otf_pkg

// File: hdl/otf_sync2.sv
// Two-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ns
module otf_sync2 #(
  parameter int W = 1
) (
  input logic i_clk,
  input logic i_rst,
  input logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } otf_sync_t;

  otf_sync_t q;
  otf_sync_t d;

  always_comb begin
    d.s1 = i_d;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_q = q.s2;

endmodule : otf_sync2

// File: hdl/otf_cmd_cdc.sv
// Toggle handshake carrying one command at a time from the link clock to the reference clock.
`timescale 1ns/1ns
module otf_cmd_cdc import otf_pkg::*; (
  input logic i_ref_clk,
  input logic i_sys_rst,
  input logic i_lnk_clk,
  input logic i_cmd_valid,
  input logic i_cmd_write,
  input logic [7:0] i_cmd_code,
  input logic [15:0] i_cmd_wdata,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_rdata,
  output logic o_req_pulse,
  output logic o_req_write,
  output logic [7:0] o_req_code,
  output logic [15:0] o_req_wdata,
  input logic [15:0] i_req_rdata
);

  typedef struct packed {
    logic req_tgl;
    logic busy;
    logic ready;
    logic ack_seen;
    logic wr;
    logic [7:0] code;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rsp_valid;
  } otf_lnk_t;

  typedef struct packed {
    logic req_seen;
    logic pulse;
    logic ack_tgl;
    logic [15:0] rdata;
  } otf_ref_t;

  otf_lnk_t lq;
  otf_lnk_t ld;
  otf_ref_t rq;
  otf_ref_t rd;
  logic req_sync;
  logic ack_sync;

  otf_sync2 #(.W(1)) u_req_sync (
    .i_clk(i_ref_clk),
    .i_rst(i_sys_rst),
    .i_d(lq.req_tgl),
    .o_q(req_sync)
  );

  otf_sync2 #(.W(1)) u_ack_sync (
    .i_clk(i_lnk_clk),
    .i_rst(i_sys_rst),
    .i_d(rq.ack_tgl),
    .o_q(ack_sync)
  );

  // Command fields stay frozen while busy, so the reference side may sample them.
  always_comb begin
    ld = lq;
    ld.rsp_valid = 1'b0;
    if (!lq.busy && i_cmd_valid) begin
      ld.req_tgl = ~lq.req_tgl;
      ld.busy = 1'b1;
      ld.wr = i_cmd_write;
      ld.code = i_cmd_code;
      ld.wdata = i_cmd_wdata;
    end else if (lq.busy && (ack_sync != lq.ack_seen)) begin
      ld.ack_seen = ack_sync;
      ld.busy = 1'b0;
      ld.rdata = rq.rdata;
      ld.rsp_valid = ~lq.wr;
    end
    ld.ready = ~ld.busy;
  end

  always_ff @(posedge i_lnk_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  always_comb begin
    rd = rq;
    rd.pulse = 1'b0;
    if (req_sync != rq.req_seen) begin
      rd.req_seen = req_sync;
      rd.pulse = 1'b1;
    end
    if (rq.pulse) begin
      rd.rdata = i_req_rdata;
      rd.ack_tgl = ~rq.ack_tgl;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rq <= '0;
    end else begin
      rq <= rd;
    end
  end

  assign o_cmd_ready = lq.ready;
  assign o_rsp_valid = lq.rsp_valid;
  assign o_rsp_rdata = lq.rdata;
  assign o_req_pulse = rq.pulse;
  assign o_req_write = lq.wr;
  assign o_req_code = lq.code;
  assign o_req_wdata = lq.wdata;

endmodule : otf_cmd_cdc

// File: hdl/otf_top.sv
// Over-temperature limits, response configuration and fault response sequencer.
`timescale 1ns/1ns
module otf_top import otf_pkg::*; #(
  parameter int P_TICK_CYC = TICK_CYC
) (
  input logic i_ref_clk,
  input logic i_sys_rst,
  input logic i_lnk_clk,
  input logic i_cmd_valid,
  input logic i_cmd_write,
  input logic [7:0] i_cmd_code,
  input logic [15:0] i_cmd_wdata,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_rdata,
  input logic [15:0] i_temp,
  input logic i_ctrl_on,
  input logic i_bias_ok,
  input logic i_op_on,
  input logic i_other_shutdown,
  input logic i_clear_faults,
  output logic o_output_en,
  output logic o_alert_line_n,
  output logic o_fault_flag,
  output logic o_warn_flag
);

  localparam int PW = $clog2(P_TICK_CYC + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(P_TICK_CYC - 1);

  typedef struct packed {
    logic [15:0] fault_thr;
    logic [15:0] warn_thr;
    logic [7:0] resp_cfg;
    logic [15:0] unit;
    otf_state_t state;
    logic [DELAY_W-1:0] delay_cnt;
    logic [PW-1:0] pre_cnt;
    logic [2:0] retry_left;
    logic retry_inf;
    logic fault_flag;
    logic warn_flag;
    logic out_en;
    logic alert_n;
  } otf_top_t;

  otf_top_t q;
  otf_top_t d;

  logic req_pulse;
  logic req_write;
  logic [7:0] req_code;
  logic [15:0] req_wdata;
  logic [15:0] req_rdata;
  logic [1:0] pins_sync;
  logic fault_now;
  logic warn_now;
  logic on_ok;
  logic tick;
  logic expired;
  logic out_of_retries;
  otf_resp_t resp;
  logic [2:0] retry_cfg;
  logic [DELAY_W-1:0] delay_load;

  otf_cmd_cdc u_cdc (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_lnk_clk(i_lnk_clk),
    .i_cmd_valid(i_cmd_valid),
    .i_cmd_write(i_cmd_write),
    .i_cmd_code(i_cmd_code),
    .i_cmd_wdata(i_cmd_wdata),
    .o_cmd_ready(o_cmd_ready),
    .o_rsp_valid(o_rsp_valid),
    .o_rsp_rdata(o_rsp_rdata),
    .o_req_pulse(req_pulse),
    .o_req_write(req_write),
    .o_req_code(req_code),
    .o_req_wdata(req_wdata),
    .i_req_rdata(req_rdata)
  );

  // The control pin and the bias-good pin arrive asynchronously.
  otf_sync2 #(.W(2)) u_pin_sync (
    .i_clk(i_ref_clk),
    .i_rst(i_sys_rst),
    .i_d({i_ctrl_on, i_bias_ok}),
    .o_q(pins_sync)
  );

  assign fault_now = otf_lin_ge(i_temp, q.fault_thr);
  assign warn_now = otf_lin_ge(i_temp, q.warn_thr);
  // Either the pin or the command turning off, bias loss or another fault stops retrying.
  assign on_ok = pins_sync[1] & pins_sync[0] & i_op_on & ~i_other_shutdown;
  assign tick = (q.pre_cnt == PRE_LAST);
  // Ending on the last tick, not one cycle after it, keeps the spacing exact.
  assign expired = (q.delay_cnt == '0) || ((q.delay_cnt == DELAY_W'(1)) && tick);
  assign resp = otf_resp_t'(q.resp_cfg[RESP_HI:RESP_LO]);
  assign retry_cfg = q.resp_cfg[RETRY_HI:RETRY_LO];
  // One delay value serves both the run-on time and the restart spacing.
  assign delay_load = otf_delay_ticks(q.unit, q.resp_cfg[DELAY_HI:DELAY_LO]);
  assign out_of_retries = (q.retry_left == RETRY_NONE) && !q.retry_inf;

  // Register reads are answered from the current contents; unknown codes read zero.
  always_comb begin
    case (req_code)
      CODE_FAULT_THRESH: req_rdata = q.fault_thr;
      CODE_RESP_CFG: req_rdata = {8'h00, q.resp_cfg};
      CODE_WARN_THRESH: req_rdata = q.warn_thr;
      CODE_DELAY_UNIT: req_rdata = q.unit;
      default: req_rdata = 16'h0000;
    endcase
  end

  always_comb begin
    d = q;
    d.pre_cnt = tick ? '0 : q.pre_cnt + PW'(1);
    if (tick && (q.delay_cnt != '0)) begin
      d.delay_cnt = q.delay_cnt - DELAY_W'(1);
    end

    if (req_pulse && req_write) begin
      case (req_code)
        CODE_FAULT_THRESH: d.fault_thr = req_wdata;
        CODE_RESP_CFG: d.resp_cfg = req_wdata[7:0];
        CODE_WARN_THRESH: d.warn_thr = req_wdata;
        CODE_DELAY_UNIT: d.unit = req_wdata;
        default: d.unit = q.unit;
      endcase
    end

    case (q.state)
      ST_RUN: begin
        if (fault_now && on_ok && (resp != RESP_IGNORE)) begin
          // A new episode reloads both counters.
          d.retry_left = retry_cfg;
          d.retry_inf = (retry_cfg == RETRY_FOREVER);
          d.delay_cnt = delay_load;
          d.pre_cnt = '0;
          case (resp)
            RESP_RETRY_RUN: d.state = ST_CONT;
            RESP_DISABLE_RETRY: begin
              d.state = (retry_cfg == RETRY_NONE) ? ST_LATCH : ST_OFF_WAIT;
            end
            RESP_RESUME_OK: d.state = ST_HOLD;
            default: d.state = ST_RUN;
          endcase
        end
      end
      ST_CONT: begin
        if (expired) begin
          if (fault_now) begin
            // Still hot after the run-on time: shut down and follow the retry setting.
            d.state = out_of_retries ? ST_LATCH : ST_OFF_WAIT;
            d.delay_cnt = delay_load;
            d.pre_cnt = '0;
          end else begin
            d.state = ST_RUN;
          end
        end
      end
      ST_OFF_WAIT: begin
        if (expired) begin
          d.state = ST_RESTART;
          d.delay_cnt = delay_load;
          d.pre_cnt = '0;
          if (!q.retry_inf) begin
            d.retry_left = q.retry_left - 3'h1;
          end
        end
      end
      ST_RESTART: begin
        // The counter is not reloaded on failure, so spacing runs start to start.
        if (fault_now) begin
          d.state = out_of_retries ? ST_LATCH : ST_OFF_WAIT;
        end else if (expired) begin
          d.state = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!fault_now) begin
          d.state = ST_RUN;
        end
      end
      ST_LATCH: begin
        if (i_clear_faults) begin
          d.state = ST_RUN;
        end
      end
      default: d.state = ST_RUN;
    endcase

    // Commanded off or loss of bias ends any sequence except a latched shutdown.
    if (!on_ok && (q.state != ST_LATCH)) begin
      d.state = ST_RUN;
    end

    // Clearing first, then setting, so a fault in the clear cycle is kept.
    if (i_clear_faults) begin
      d.fault_flag = 1'b0;
      d.warn_flag = 1'b0;
    end
    if (fault_now && (resp != RESP_IGNORE)) begin
      d.fault_flag = 1'b1;
    end
    if (warn_now) begin
      d.warn_flag = 1'b1;
    end
    d.alert_n = ~d.fault_flag;

    d.out_en = on_ok && ((d.state == ST_RUN) || (d.state == ST_CONT) ||
                         (d.state == ST_RESTART));
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.fault_thr <= RST_FAULT_THRESH;
      q.warn_thr <= RST_WARN_THRESH;
      q.resp_cfg <= RST_RESP_CFG;
      q.unit <= RST_DELAY_UNIT;
      q.state <= ST_RUN;
      q.alert_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_output_en = q.out_en;
  assign o_alert_line_n = q.alert_n;
  assign o_fault_flag = q.fault_flag;
  assign o_warn_flag = q.warn_flag;

endmodule : otf_top

// File: testbench/otf_properties.sv
// Port assertions for the over-temperature fault response block.
`timescale 1ns/1ns
module otf_properties (
  input logic i_ref_clk,
  input logic i_sys_rst,
  input logic i_lnk_clk,
  input logic i_cmd_valid,
  input logic o_cmd_ready,
  input logic o_rsp_valid,
  input logic i_op_on,
  input logic i_clear_faults,
  input logic o_output_en,
  input logic o_alert_line_n,
  input logic o_fault_flag,
  input logic o_warn_flag
);
  a_alert_flag: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst) o_alert_line_n == !o_fault_flag)
    else $error("alert differs from fault flag");
  a_fault_sticky: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst) o_fault_flag && !i_clear_faults |=> o_fault_flag)
    else $error("fault flag dropped");
  a_warn_sticky: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst) o_warn_flag && !i_clear_faults |=> o_warn_flag)
    else $error("warning flag dropped");
  a_op_off: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst) !i_op_on [*3] |=> !o_output_en)
    else $error("output on while commanded off");
  a_rise_needs_on: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst) $rose(o_output_en) |-> $past(i_op_on))
    else $error("output rose while commanded off");
  a_take_drops_ready: assert property (
    @(posedge i_lnk_clk) disable iff (i_sys_rst) i_cmd_valid && o_cmd_ready |=> !o_cmd_ready)
    else $error("ready stayed high after a command");
  a_ready_returns: assert property (
    @(posedge i_lnk_clk) disable iff (i_sys_rst) $fell(o_cmd_ready) |-> ##[2:20] o_cmd_ready)
    else $error("command never answered");
  a_rsp_one_pulse: assert property (
    @(posedge i_lnk_clk) disable iff (i_sys_rst) o_rsp_valid |-> o_cmd_ready ##1 !o_rsp_valid)
    else $error("read answer malformed");
endmodule : otf_properties
bind otf_top otf_properties u_props (
  .i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst),
  .i_lnk_clk(i_lnk_clk),
  .i_cmd_valid(i_cmd_valid),
  .o_cmd_ready(o_cmd_ready),
  .o_rsp_valid(o_rsp_valid),
  .i_op_on(i_op_on),
  .i_clear_faults(i_clear_faults),
  .o_output_en(o_output_en),
  .o_alert_line_n(o_alert_line_n),
  .o_fault_flag(o_fault_flag),
  .o_warn_flag(o_warn_flag)
);

// File: testbench/otf_host_model.sv
// Command link host model issuing one register command at a time.
`timescale 1ns/1ns
module otf_host_model (
  input logic i_lnk_clk,
  input logic i_cmd_ready,
  input logic i_rsp_valid,
  input logic [15:0] i_rsp_rdata,
  output logic o_cmd_valid = 1'b0,
  output logic o_cmd_write = 1'b0,
  output logic [7:0] o_cmd_code = 8'h00,
  output logic [15:0] o_cmd_wdata = 16'h0000
);
  // Idle code and data lines carry the inverse of the last request, so stale data never looks fresh.
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] r, output logic ok);
    int k = 0;
    logic got = 1'b0;
    r = 16'h0000;
    @(posedge i_lnk_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_write <= wr;
    o_cmd_code <= c;
    o_cmd_wdata <= d;
    do begin
      @(posedge i_lnk_clk);
      k++;
    end while (i_cmd_ready !== 1'b1 && k < 40);
    o_cmd_valid <= 1'b0;
    o_cmd_code <= ~c;
    o_cmd_wdata <= ~d;
    do begin
      @(posedge i_lnk_clk);
      k++;
      if (i_rsp_valid === 1'b1) begin
        r = i_rsp_rdata;
        got = 1'b1;
      end
    end while (i_cmd_ready !== 1'b1 && k < 80);
    ok = i_cmd_ready && (wr || got);
  endtask : xfer
endmodule : otf_host_model

// File: testbench/tb.sv
// Self-checking bench for the over-temperature fault response block.
`timescale 1ns/1ns
module tb;
  import otf_pkg::*;
  // A short tick keeps every delay code within a few hundred cycles.
  localparam int TK = 4;
  localparam logic [15:0] HOT = 16'h0064;
  localparam logic [15:0] WARM = 16'h005A;
  localparam logic [15:0] COOL = 16'h0032;
  logic i_ref_clk, i_lnk_clk, i_cmd_valid, i_cmd_write, o_cmd_ready, o_rsp_valid;
  logic i_sys_rst = 1'b1, i_ctrl_on = 1'b1, i_bias_ok = 1'b1, i_op_on = 1'b1;
  logic i_other_shutdown = 1'b0, i_clear_faults = 1'b0;
  logic o_output_en, o_alert_line_n, o_fault_flag, o_warn_flag;
  logic [7:0] i_cmd_code;
  logic [15:0] i_cmd_wdata, o_rsp_rdata, rd;
  logic [15:0] i_temp = COOL;
  int mismatches = 0;
  int n_compared = 0;
  int n, g;

  otf_top #(.P_TICK_CYC(TK)) u_dut (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_lnk_clk(i_lnk_clk),
    .i_cmd_valid(i_cmd_valid),
    .i_cmd_write(i_cmd_write),
    .i_cmd_code(i_cmd_code),
    .i_cmd_wdata(i_cmd_wdata),
    .o_cmd_ready(o_cmd_ready),
    .o_rsp_valid(o_rsp_valid),
    .o_rsp_rdata(o_rsp_rdata),
    .i_temp(i_temp),
    .i_ctrl_on(i_ctrl_on),
    .i_bias_ok(i_bias_ok),
    .i_op_on(i_op_on),
    .i_other_shutdown(i_other_shutdown),
    .i_clear_faults(i_clear_faults),
    .o_output_en(o_output_en),
    .o_alert_line_n(o_alert_line_n),
    .o_fault_flag(o_fault_flag),
    .o_warn_flag(o_warn_flag)
  );
  otf_host_model u_host (
    .i_lnk_clk(i_lnk_clk),
    .i_cmd_ready(o_cmd_ready),
    .i_rsp_valid(o_rsp_valid),
    .i_rsp_rdata(o_rsp_rdata),
    .o_cmd_valid(i_cmd_valid),
    .o_cmd_write(i_cmd_write),
    .o_cmd_code(i_cmd_code),
    .o_cmd_wdata(i_cmd_wdata)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_lnk_clk = 1'b0;
    #4;
    forever begin
      #7 i_lnk_clk = 1'b1;
      #8 i_lnk_clk = 1'b0;
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic chk1(input string what, input logic seen, input logic exp);
    check(what, {15'h0000, seen}, {15'h0000, exp});
  endtask : chk1

  task automatic tick(input int k);
    repeat (k) @(posedge i_ref_clk);
  endtask : tick

  task automatic cmd(input logic wr, input logic [7:0] c, input logic [15:0] d);
    logic ok;
    u_host.xfer(wr, c, d, rd, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected link_answer expected 1 seen %b", ok);
      tally_and_finish();
    end
  endtask : cmd

  task automatic wr_rd(input logic [7:0] c, input logic [15:0] d, input logic [15:0] exp);
    cmd(1'b1, c, d);
    cmd(1'b0, c, 16'h0000);
    check("readback", rd, exp);
  endtask : wr_rd

  task automatic heat(input logic [15:0] t);
    @(posedge i_ref_clk);
    i_temp <= t;
  endtask : heat

  // Counts restart attempts as rising edges of the enable and keeps the first spacing.
  task automatic count_rises(input int cyc);
    int first = 0;
    logic prev = o_output_en;
    n = 0;
    g = 0;
    for (int t = 0; t < cyc; t++) begin
      @(posedge i_ref_clk);
      if (o_output_en && !prev) begin
        n++;
        if (n == 1) first = t;
        if (n == 2) g = t - first;
      end
      prev = o_output_en;
    end
  endtask : count_rises

  // Cooling first matters: a set flag outranks a clear in the same cycle.
  task automatic recover();
    heat(COOL);
    tick(3);
    i_clear_faults <= 1'b1;
    tick(1);
    i_clear_faults <= 1'b0;
    tick(1);
    for (int k = 0; k < 40 && o_output_en !== 1'b1; k++) tick(1);
    chk1("out_en", o_output_en, 1'b1);
    chk1("fault", o_fault_flag, 1'b0);
    if (o_output_en !== 1'b1) tally_and_finish();
  endtask : recover

  task automatic s_regs();
    // 111 C with exponent 0 against reset limits held with exponent -3.
    heat(16'h006F);
    tick(3);
    chk1("warn", o_warn_flag, 1'b1);
    chk1("fault", o_fault_flag, 1'b0);
    recover();
    cmd(1'b0, CODE_FAULT_THRESH, 16'h0000);
    check("fault_thr", rd, RST_FAULT_THRESH);
    cmd(1'b0, CODE_WARN_THRESH, 16'h0000);
    check("warn_thr", rd, RST_WARN_THRESH);
    cmd(1'b0, CODE_RESP_CFG, 16'h0000);
    check("resp_cfg", rd, {8'h00, RST_RESP_CFG});
    cmd(1'b0, 8'h99, 16'h0000);
    check("unmapped", rd, 16'h0000);
    wr_rd(CODE_FAULT_THRESH, HOT, HOT);
    wr_rd(CODE_WARN_THRESH, WARM, WARM);
    wr_rd(CODE_RESP_CFG, 16'hFFC5, 16'h00C5);
    wr_rd(CODE_DELAY_UNIT, 16'h0001, 16'h0001);
  endtask : s_regs

  task automatic s_ignore();
    cmd(1'b1, CODE_RESP_CFG, 16'h0000);
    heat(WARM);
    tick(4);
    chk1("warn", o_warn_flag, 1'b1);
    chk1("fault", o_fault_flag, 1'b0);
    heat(HOT);
    tick(20);
    chk1("out_en", o_output_en, 1'b1);
    chk1("alert_n", o_alert_line_n, 1'b1);
    recover();
    chk1("warn", o_warn_flag, 1'b0);
  endtask : s_ignore

  task automatic s_resume();
    cmd(1'b1, CODE_RESP_CFG, 16'h00C0);
    heat(HOT);
    tick(4);
    chk1("out_en", o_output_en, 1'b0);
    chk1("alert_n", o_alert_line_n, 1'b0);
    heat(COOL);
    tick(6);
    chk1("out_en", o_output_en, 1'b1);
    recover();
  endtask : s_resume

  task automatic s_no_retry();
    cmd(1'b1, CODE_RESP_CFG, 16'h0080);
    heat(HOT);
    tick(3);
    chk1("out_en", o_output_en, 1'b0);
    heat(COOL);
    count_rises(40);
    check("restarts", 16'(n), 16'h0000);
    recover();
  endtask : s_no_retry

  task automatic s_retries();
    for (int k = 1; k < 7; k++) begin
      cmd(1'b1, CODE_RESP_CFG, 16'h0080 | 16'(k << 3));
      heat(HOT);
      count_rises(60);
      check("restarts", 16'(n), 16'(k));
      recover();
    end
  endtask : s_retries

  task automatic s_spacing();
    cmd(1'b1, CODE_DELAY_UNIT, 16'h0002);
    cmd(1'b1, CODE_RESP_CFG, 16'h0091);
    heat(HOT);
    count_rises(100);
    check("gap", 16'(g), 16'(4 * TK));
    recover();
    cmd(1'b1, CODE_DELAY_UNIT, 16'h0001);
  endtask : s_spacing

  task automatic s_run_first();
    cmd(1'b1, CODE_RESP_CFG, 16'h0049);
    heat(HOT);
    tick(5);
    chk1("out_en", o_output_en, 1'b1);
    chk1("fault", o_fault_flag, 1'b1);
    count_rises(60);
    check("restarts", 16'(n), 16'h0001);
    recover();
  endtask : s_run_first

  task automatic s_forever();
    cmd(1'b1, CODE_RESP_CFG, 16'h00B8);
    heat(HOT);
    count_rises(60);
    chk1("many", n > 6, 1'b1);
    i_op_on <= 1'b0;
    count_rises(30);
    check("restarts", 16'(n), 16'h0000);
    i_op_on <= 1'b1;
    i_bias_ok <= 1'b0;
    count_rises(30);
    check("restarts", 16'(n), 16'h0000);
    i_bias_ok <= 1'b1;
    i_ctrl_on <= 1'b0;
    count_rises(30);
    check("restarts", 16'(n), 16'h0000);
    i_ctrl_on <= 1'b1;
    i_other_shutdown <= 1'b1;
    count_rises(30);
    check("restarts", 16'(n), 16'h0000);
    i_other_shutdown <= 1'b0;
    recover();
  endtask : s_forever

  initial begin
    tick(10);
    i_sys_rst <= 1'b0;
    tick(6);
    s_regs();
    s_ignore();
    s_resume();
    s_no_retry();
    s_retries();
    s_spacing();
    s_run_first();
    s_forever();
    tally_and_finish();
  end
endmodule : tb
